// ===== common/group_sel_pkg.sv
// Purpose: Shared constants for the parameter set selector
// Assumes: APB slave with 32-bit data, byte addresses
// Notes: Offsets are word aligned; unlisted offsets answer with an error
`default_nettype none
package group_sel_pkg;
    // Number of parameter sets and index width
    localparam int NSETS = 8;
    localparam int IDX_W = 3;
    localparam int ADDR_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CONFIG = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_FORCE = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_REMOTE = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL = 8'h0C;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] ADDR_EVENT = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_MASK = 8'h18;

    // Configuration fields
    localparam int CFG_FORCE_BIT = 0;
    localparam int CFG_USED_LSB = 4;
    localparam logic CFG_FORCE_RST = 1'b0;
    localparam logic [IDX_W-1:0] CFG_USED_RST = 3'h0;

    // Change request fields: 0 none, 1..8 selects a set
    localparam int SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'h8;

    // Status fields
    localparam int ST_ACT_LSB = 0;
    localparam int ST_REQ_LSB = 8;
    localparam int ST_CFG_LSB = 16;
    localparam int ST_FAIL_LSB = 24;

    // Event status bit positions
    localparam int EV_ACT_LSB = 0;
    localparam int EV_REQ_LSB = 8;
    localparam int EV_ENA_LSB = 16;
    localparam int EV_MISC_LSB = 23;

    // Miscellaneous level order, used by the events only
    localparam int MISC_W = 6;
    localparam int M_REMOTE = 0;
    localparam int M_LOCAL = 1;
    localparam int M_FORCE = 2;
    localparam int M_FAIL_CFG = 3;
    localparam int M_FAIL_FRC = 4;
    localparam int M_FAIL_LOW = 5;

    // Reset values
    localparam logic [IDX_W-1:0] ACTIVE_RST = 3'h0;
    localparam logic [NSETS-1:0] ACT_ONEHOT_RST = 8'h01;
    localparam logic [31:0] MASK_RST = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== hw/edge_event.sv
// Purpose: Turns levels into registered ON and OFF event pulses
// Assumes: Levels are synchronous to pclk
// Notes: Reset value of the history avoids spurious events at power-up
`default_nettype none
module edge_event #(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Watched levels
    input wire logic [W-1:0] lvl,
    // One-cycle event pulses
    output logic [W-1:0] on_evt,
    output logic [W-1:0] off_evt
);
    logic [W-1:0] prev; // Level seen last cycle

    // History of the levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= RST;
        end else begin
            prev <= lvl;
        end
    end

    // Rising edge gives ON, falling edge gives OFF
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_evt <= '0;
            off_evt <= '0;
        end else begin
            on_evt <= lvl & ~prev;
            off_evt <= ~lvl & prev;
        end
    end

    // Every change produces exactly its own pulse one cycle later
    edge_pulse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (lvl != prev) |=> ((on_evt | off_evt) == $past(lvl ^ prev))
    ) else $error("edge event pulse missing or misplaced");
endmodule
`default_nettype wire

// ===== hw/set_priority.sv
// Purpose: Finds the highest-priority set among held requests
// Assumes: Index 0 is the highest priority
// Notes: Purely combinational; the caller registers what it needs
`default_nettype none
module set_priority
    import group_sel_pkg::*;
(
    // Request levels, one per set
    input wire logic [NSETS-1:0] vec,
    // Winning index and whether any is held
    output logic [IDX_W-1:0] idx,
    output logic any
);
    // Scan from lowest priority upward so the lowest index wins
    always_comb begin
        idx = '0;
        any = 1'b0;
        for (int i = NSETS - 1; i >= 0; i--) begin
            if (vec[i]) begin
                idx = IDX_W'(i);
                any = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/group_selector_event_block.sv
// Purpose: Selects the active parameter set and reports its events
// Assumes: Request levels come from relay logic, synchronous to pclk
// Notes: Registers over APB; zero wait state, error on unmapped offset
//
// The register addresses and the APB register port were decided locally.
`default_nettype none
module group_selector_event_block
    import group_sel_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [group_sel_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Request levels from application logic
    input wire logic [group_sel_pkg::NSETS-1:0] set_request,
    // Active set
    output logic [group_sel_pkg::IDX_W-1:0] active_set,
    // Per-set events
    output logic [group_sel_pkg::NSETS-1:0] req_on_evt,
    output logic [group_sel_pkg::NSETS-1:0] req_off_evt,
    output logic [group_sel_pkg::NSETS-1:0] act_on_evt,
    output logic [group_sel_pkg::NSETS-1:0] act_off_evt,
    // Enable events for sets two to eight
    output logic [group_sel_pkg::NSETS-2:0] enabled_evt,
    output logic [group_sel_pkg::NSETS-2:0] disabled_evt,
    // Remote, local, force and failure events
    output logic [group_sel_pkg::MISC_W-1:0] misc_on_evt,
    output logic [group_sel_pkg::MISC_W-1:0] misc_off_evt,
    // Interrupt
    output logic irq
);
    import group_sel_pkg::*;

    // Software state
    logic force_en; // Forced changes allowed
    logic [IDX_W-1:0] used_cnt; // Highest configured set index
    logic [SEL_W-1:0] force_sel; // Last forced request
    logic [SEL_W-1:0] remote_sel; // Last remote request
    logic [SEL_W-1:0] local_sel; // Last local request
    logic [31:0] evt_stat; // Sticky event bits
    logic [31:0] evt_mask; // Interrupt mask

    // Pending command from a register write
    logic cmd_valid;
    logic cmd_forced;
    logic [IDX_W-1:0] cmd_set;

    // Selection state
    logic [NSETS-1:0] req_q; // Requests last cycle
    logic [IDX_W-1:0] hidx_q; // Winner last cycle
    logic any_q; // Any request held last cycle
    logic fail_cfg; // Not-configured failure level
    logic fail_force; // Force failure level
    logic fail_low; // Lower-priority failure level

    // APB decode
    logic wr_acc; // Write access completes
    logic rd_acc; // Read access completes
    logic setup; // Setup phase
    logic hit; // Mapped address
    logic [31:0] rd_word; // Read mux

    // Combinational selection terms
    logic [NSETS-1:0] cfg_mask;
    logic [IDX_W-1:0] hidx;
    logic any_held;
    logic [NSETS-1:0] rise;
    logic [NSETS-1:0] low_mask;
    logic level_apply;
    logic reject_force;
    logic reject_low;
    logic reject_cfg;
    logic accept_cmd;
    logic [IDX_W-1:0] next_active;

    // Event plumbing
    logic [NSETS-1:0] act_onehot;
    logic [MISC_W-1:0] misc_lvl;
    logic [31:0] evt_set;

    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pwrite;
    assign rd_acc = psel & penable & ~pwrite;

    // Winner among held request levels
    set_priority u_prio (
        .vec(set_request),
        .idx(hidx),
        .any(any_held)
    );

    // Sets up to the used count are configured; the first always is
    always_comb begin
        for (int i = 0; i < NSETS; i++) begin
            cfg_mask[i] = (IDX_W'(i) <= used_cnt);
        end
    end

    // Decisions on requests
    always_comb begin
        rise = set_request & ~req_q;
        low_mask = NSETS'(8'hFF << ({1'b0, hidx} + 4'h1));
        // A new winner, or a request after none, is applied once
        level_apply = any_held & (~any_q | (hidx != hidx_q));
        reject_force = cmd_valid & ~force_en;
        reject_low = cmd_valid & force_en & ~cmd_forced & any_held
            & (hidx < cmd_set);
        reject_cfg = cmd_valid & force_en & ~reject_low
            & ~cfg_mask[cmd_set];
        accept_cmd = cmd_valid & ~reject_force & ~reject_low
            & ~reject_cfg;
        next_active = active_set;
        if (accept_cmd) begin
            next_active = cmd_set;
        end else if (level_apply && cfg_mask[hidx]) begin
            // Falling top request hands over to the next held one
            next_active = hidx;
        end
    end

    // Active set only moves on an accepted change or an applied level winner
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_set <= ACTIVE_RST;
        end else begin
            active_set <= next_active;
        end
    end

    // Request history for edge and winner tracking
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_q <= '0;
            hidx_q <= '0;
            any_q <= 1'b0;
        end else begin
            req_q <= set_request;
            hidx_q <= hidx;
            any_q <= any_held;
        end
    end

    // Failure levels; a new rejection beats any clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_cfg <= 1'b0;
            fail_force <= 1'b0;
            fail_low <= 1'b0;
        end else begin
            if (reject_cfg || (level_apply && !cfg_mask[hidx])) begin
                fail_cfg <= 1'b1;
            end else if (accept_cmd || (level_apply && cfg_mask[hidx])) begin
                fail_cfg <= 1'b0;
            end
            if (reject_force) begin
                fail_force <= 1'b1;
            end else if (accept_cmd || force_en) begin
                fail_force <= 1'b0;
            end
            // Lower request while a higher one is held is refused
            if (reject_low || (any_held && |(rise & low_mask))) begin
                fail_low <= 1'b1;
            end else if (!any_held) begin
                fail_low <= 1'b0;
            end
        end
    end

    // Writes to change registers queue one command for next cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmd_valid <= 1'b0;
            cmd_forced <= 1'b0;
            cmd_set <= '0;
        end else begin
            cmd_valid <= 1'b0;
            if (wr_acc && pwdata[SEL_W-1:0] != SEL_NONE
                && pwdata[SEL_W-1:0] <= SEL_MAX) begin
                cmd_set <= IDX_W'(pwdata[SEL_W-1:0] - 4'h1);
                cmd_forced <= (paddr == ADDR_FORCE);
                cmd_valid <= (paddr == ADDR_FORCE)
                    || (paddr == ADDR_REMOTE) || (paddr == ADDR_LOCAL);
            end
        end
    end

    // Configuration and request registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            force_en <= CFG_FORCE_RST;
            used_cnt <= CFG_USED_RST;
            force_sel <= SEL_NONE;
            remote_sel <= SEL_NONE;
            local_sel <= SEL_NONE;
            evt_mask <= MASK_RST;
        end else if (wr_acc) begin
            case (paddr)
                ADDR_CONFIG: begin
                    force_en <= pwdata[CFG_FORCE_BIT];
                    used_cnt <= pwdata[CFG_USED_LSB +: IDX_W];
                end
                ADDR_FORCE: force_sel <= pwdata[SEL_W-1:0];
                ADDR_REMOTE: remote_sel <= pwdata[SEL_W-1:0];
                ADDR_LOCAL: local_sel <= pwdata[SEL_W-1:0];
                ADDR_MASK: evt_mask <= pwdata;
                default: begin
                    // Read-only or unmapped: no effect
                end
            endcase
        end
    end

    // Read mux for the setup phase
    always_comb begin
        hit = 1'b1;
        rd_word = ZERO_WORD;
        case (paddr)
            ADDR_CONFIG: begin
                rd_word[CFG_FORCE_BIT] = force_en;
                rd_word[CFG_USED_LSB +: IDX_W] = used_cnt;
            end
            ADDR_FORCE: rd_word[SEL_W-1:0] = force_sel;
            ADDR_REMOTE: rd_word[SEL_W-1:0] = remote_sel;
            ADDR_LOCAL: rd_word[SEL_W-1:0] = local_sel;
            ADDR_STATUS: begin
                rd_word[ST_ACT_LSB +: IDX_W] = active_set;
                rd_word[ST_REQ_LSB +: NSETS] = set_request;
                rd_word[ST_CFG_LSB +: NSETS] = cfg_mask;
                rd_word[ST_FAIL_LSB +: 3] = {fail_low, fail_force, fail_cfg};
            end
            ADDR_EVENT: rd_word = evt_stat;
            ADDR_MASK: rd_word = evt_mask;
            default: hit = 1'b0;
        endcase
    end

    // Data and error captured in setup, so the access completes at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ZERO_WORD;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                prdata <= pwrite ? ZERO_WORD : rd_word;
                pslverr <= ~hit;
            end
        end
    end

    // Event sources
    always_comb begin
        act_onehot = NSETS'(1) << active_set;
        misc_lvl = '0;
        misc_lvl[M_REMOTE] = (remote_sel != SEL_NONE);
        misc_lvl[M_LOCAL] = (local_sel != SEL_NONE);
        misc_lvl[M_FORCE] = force_en;
        misc_lvl[M_FAIL_CFG] = fail_cfg;
        misc_lvl[M_FAIL_FRC] = fail_force;
        misc_lvl[M_FAIL_LOW] = fail_low;
    end

    // Request input edges
    edge_event #(.W(NSETS), .RST('0)) u_req_ev (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(set_request),
        .on_evt(req_on_evt),
        .off_evt(req_off_evt)
    );

    // Active set edges; reset history matches the first set
    edge_event #(.W(NSETS), .RST(ACT_ONEHOT_RST)) u_act_ev (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(act_onehot),
        .on_evt(act_on_evt),
        .off_evt(act_off_evt)
    );

    // Configuration edges for sets two to eight
    edge_event #(.W(NSETS-1), .RST('0)) u_ena_ev (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(cfg_mask[NSETS-1:1]),
        .on_evt(enabled_evt),
        .off_evt(disabled_evt)
    );

    // Remote, local, force and failure edges
    edge_event #(.W(MISC_W), .RST('0)) u_misc_ev (
        .pclk(pclk),
        .presetn(presetn),
        .lvl(misc_lvl),
        .on_evt(misc_on_evt),
        .off_evt(misc_off_evt)
    );

    assign evt_set = {3'b000, misc_on_evt | misc_off_evt,
        enabled_evt | disabled_evt, req_on_evt | req_off_evt,
        act_on_evt | act_off_evt};

    // Sticky events; only bits already read are cleared, so set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            evt_stat <= ZERO_WORD;
        end else if (rd_acc && paddr == ADDR_EVENT) begin
            evt_stat <= (evt_stat & ~prdata) | evt_set;
        end else begin
            evt_stat <= evt_stat | evt_set;
        end
    end

    // Level interrupt from unmasked sticky bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evt_stat & evt_mask);
        end
    end

    // Active set changes only for an accepted change or a level winner
    first_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !accept_cmd && !level_apply |=> $stable(active_set)
    ) else $error("active set moved without a request");

    cfg_refuse_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        reject_cfg |=> fail_cfg && active_set == $past(active_set)
            ##1 misc_on_evt[M_FAIL_CFG] || $past(fail_cfg, 2)
    ) else $error("unconfigured set not refused");

    low_fail_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        reject_low |=> fail_low
    ) else $error("lower priority failure not raised");

    force_fail_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cmd_valid && !force_en |=> fail_force && $stable(active_set)
    ) else $error("force failure not raised");

    remote_evt_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_acc && paddr == ADDR_REMOTE && remote_sel == SEL_NONE
            && pwdata[SEL_W-1:0] != SEL_NONE |-> ##2 misc_on_evt[M_REMOTE]
    ) else $error("remote request ON event missing");

    prio_pick_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        level_apply && cfg_mask[hidx] && !accept_cmd
            |=> active_set == $past(hidx)
    ) else $error("priority winner not applied");

    static_block_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        any_held && any_q && hidx == hidx_q && !accept_cmd
            |=> $stable(active_set)
    ) else $error("lower request passed a static one");

    remote_low_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        cmd_valid && !cmd_forced && any_held && hidx < cmd_set
            |=> active_set != $past(cmd_set)
            || $past(active_set) == $past(cmd_set)
    ) else $error("remote beat a held higher set");
endmodule
`default_nettype wire

// ===== tb/app_logic_model.sv
// Purpose: Relay application logic that drives the set request levels
// Assumes: Mode 0 one-wire coil, mode 1 automatic, mode 2 direct levels
// Notes: Levels change only right after a rising edge of pclk
`default_nettype none
module app_logic_model
    import group_sel_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Scheme controls
    input wire logic [1:0] mode,
    input wire logic coil,
    input wire logic auto_cond,
    input wire logic [group_sel_pkg::NSETS-1:0] raw,
    // Requests towards the selector
    output logic [group_sel_pkg::NSETS-1:0] set_request
);
    import group_sel_pkg::*;
    // Registered so a request never moves in the sampling step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            set_request <= '0;
        end else if (mode == 2'd0) begin
            // Coil present asks first set; broken wire gives second
            set_request <= {6'h00, !coil, coil};
        end else if (mode == 2'd1) begin
            // Second set held as normal, first only while automatic
            set_request <= {6'h00, 1'b1, auto_cond};
        end else begin
            set_request <= raw;
        end
    end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Purpose: Self-checking bench for the parameter set selector
// Assumes: Zero wait state APB slave; events caught in sticky copies
// Notes: Event pulses are too short to poll, so they are accumulated
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import group_sel_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [NSETS-1:0] set_request, raw, req_on, req_off, act_on, act_off;
    logic [NSETS-1:0] s_ron, s_roff, s_aon, s_aoff;
    logic [NSETS-2:0] ena, dis, s_ena, s_dis;
    logic [MISC_W-1:0] mon, moff, s_mon, s_moff;
    logic [IDX_W-1:0] active_set;
    logic [1:0] mode;
    logic coil, auto_cond, clr, rerr;
    int error_cnt = 0;
    int checks = 0;

    group_selector_event_block i_group_selector_event_block (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .set_request(set_request), .active_set(active_set),
        .req_on_evt(req_on), .req_off_evt(req_off), .act_on_evt(act_on),
        .act_off_evt(act_off), .enabled_evt(ena), .disabled_evt(dis),
        .misc_on_evt(mon), .misc_off_evt(moff), .irq(irq));
    app_logic_model i_app_logic_model (
        .pclk(pclk), .presetn(presetn), .mode(mode), .coil(coil),
        .auto_cond(auto_cond), .raw(raw), .set_request(set_request));

    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // Sticky copies of every event pulse, cleared on request
    always @(posedge pclk) begin
        // Reset also clears, so no unknown survives into the first checks
        if (clr || !presetn) begin
            {s_ron, s_roff, s_aon, s_aoff} <= '0;
            {s_ena, s_dis, s_mon, s_moff} <= '0;
        end else begin
            {s_ron, s_roff} <= {s_ron | req_on, s_roff | req_off};
            {s_aon, s_aoff} <= {s_aon | act_on, s_aoff | act_off};
            {s_ena, s_dis} <= {s_ena | ena, s_dis | dis};
            {s_mon, s_moff} <= {s_mon | mon, s_moff | moff};
        end
    end

    // Closing: counts, verdict, end of run
    task automatic test_done;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One compare for every kind of value
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // One APB transfer; holds the request until pready is seen high
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Write, then give a command time to settle
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        step(4);
    endtask

    task automatic clear_seen;
        @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
    endtask

    // Requests from the model, then settle; the model adds one register
    // stage, so activity events reach the sticky copies a cycle later
    task automatic req(input logic [NSETS-1:0] v);
        @(posedge pclk);
        raw <= v;
        step(5);
    endtask

    // Watchdog at 5000 cycles, well past the expected run of under two hundred cycles
    initial begin
        #(25 * 5000);
        error_cnt++;
        test_done;
    end

    initial begin
        {psel, penable, pwrite, clr, coil, auto_cond} = '0;
        paddr = '0;
        pwdata = '0;
        raw = '0;
        mode = 2'd2;
        presetn = 1'b0;
        step(3);
        presetn <= 1'b1;
        step(1);
        chk("active reset", 32'(ACTIVE_RST), 32'(active_set));
        apb(1'b0, ADDR_CONFIG, ZERO_WORD);
        chk("config reset", 32'h0000_0000, rdat);
        apb(1'b0, 8'h1C, ZERO_WORD);
        chk("unmapped err", 32'h0000_0001, 32'(rerr));
        chk("unmapped data", ZERO_WORD, rdat);
        // All sets in use, forcing on
        wr(ADDR_CONFIG, 32'h0000_0071);
        chk("enabled", 32'h0000_007F, 32'(s_ena));
        chk("force on", 32'h0000_0004, 32'(s_mon));
        // Two held levels: higher one wins
        clear_seen;
        req(8'h0C);
        chk("prio", 32'h0000_0002, 32'(active_set));
        chk("req on", 32'h0000_000C, 32'(s_ron));
        chk("act on", 32'h0000_0004, 32'(s_aon));
        chk("act off", 32'h0000_0001, 32'(s_aoff));
        // Lower level rising while a higher one is held
        req(8'h8C);
        chk("held", 32'h0000_0002, 32'(active_set));
        chk("low fail", 32'h0000_0020, 32'(s_mon & 6'h20));
        // Remote change below the held set
        clear_seen;
        wr(ADDR_REMOTE, 32'h0000_0005);
        chk("remote held", 32'h0000_0002, 32'(active_set));
        chk("remote on", 32'h0000_0001, 32'(s_mon & 6'h01));
        wr(ADDR_REMOTE, ZERO_WORD);
        chk("remote off", 32'h0000_0001, 32'(s_moff & 6'h01));
        // Release all: the set stays, low failure clears
        req(8'h00);
        chk("stays", 32'h0000_0002, 32'(active_set));
        chk("req off", 32'h0000_008C, 32'(s_roff));
        chk("low off", 32'h0000_0020, 32'(s_moff & 6'h20));
        // A one-cycle pulse latches its set
        @(posedge pclk);
        raw <= 8'h02;
        req(8'h00);
        chk("pulse", 32'h0000_0001, 32'(active_set));
        // Local change with forcing on
        clear_seen;
        wr(ADDR_LOCAL, 32'h0000_0004);
        chk("local", 32'h0000_0003, 32'(active_set));
        chk("local on", 32'h0000_0002, 32'(s_mon & 6'h02));
        wr(ADDR_LOCAL, ZERO_WORD);
        // Only the first two sets in use, then ask for the third
        wr(ADDR_CONFIG, 32'h0000_0011);
        chk("disabled", 32'h0000_007E, 32'(s_dis));
        wr(ADDR_REMOTE, 32'h0000_0003);
        chk("cfg keep", 32'h0000_0003, 32'(active_set));
        chk("cfg fail", 32'h0000_0008, 32'(s_mon & 6'h08));
        wr(ADDR_REMOTE, ZERO_WORD);
        // Forcing off, local change refused
        clear_seen;
        wr(ADDR_CONFIG, 32'h0000_0010);
        chk("force off", 32'h0000_0004, 32'(s_moff & 6'h04));
        wr(ADDR_LOCAL, 32'h0000_0001);
        chk("frc keep", 32'h0000_0003, 32'(active_set));
        chk("frc fail", 32'h0000_0010, 32'(s_mon & 6'h10));
        wr(ADDR_LOCAL, ZERO_WORD);
        // One-wire coil scheme
        mode <= 2'd0;
        coil <= 1'b1;
        step(5);
        chk("coil in", 32'h0000_0000, 32'(active_set));
        coil <= 1'b0;
        step(5);
        chk("coil out", 32'h0000_0001, 32'(active_set));
        // Automatic first set over a held second set
        mode <= 2'd1;
        auto_cond <= 1'b1;
        step(5);
        chk("auto", 32'h0000_0000, 32'(active_set));
        auto_cond <= 1'b0;
        step(5);
        chk("revert", 32'h0000_0001, 32'(active_set));
        // Forced change passes the held second set
        wr(ADDR_CONFIG, 32'h0000_0031);
        wr(ADDR_FORCE, 32'h0000_0004);
        chk("forced", 32'h0000_0003, 32'(active_set));
        // Interrupt: masked, unmasked, cleared by reading
        chk("irq masked", 32'h0000_0000, 32'(irq));
        wr(ADDR_MASK, 32'hFFFF_FFFF);
        chk("irq set", 32'h0000_0001, 32'(irq));
        apb(1'b0, ADDR_EVENT, ZERO_WORD);
        chk("evt any", 32'h0000_0001, 32'(rdat != ZERO_WORD));
        step(3);
        chk("irq clear", 32'h0000_0000, 32'(irq));
        test_done;
    end
endmodule
`default_nettype wire
